// file: design/csbp_pkg.sv
//------------------------------------------------------------------------------
// Shared constants and types of the clocked serial byte port.
//------------------------------------------------------------------------------
package csbp_pkg;

   // -------------------------------------------------------------------------
   // Bus and word widths.
   // -------------------------------------------------------------------------
   localparam int CSBP_DATA_W = 8;
   localparam int CSBP_ADDR_W = 3;
   localparam int CSBP_DIV_W = 8;

   // -------------------------------------------------------------------------
   // Register offsets on the plain register port.
   // -------------------------------------------------------------------------
   localparam logic [CSBP_ADDR_W-1:0] CSBP_OFS_MODE = 3'h0;
   localparam logic [CSBP_ADDR_W-1:0] CSBP_OFS_STATUS = 3'h1;
   localparam logic [CSBP_ADDR_W-1:0] CSBP_OFS_DIVISOR = 3'h2;
   localparam logic [CSBP_ADDR_W-1:0] CSBP_OFS_SHIFT = 3'h3;
   localparam logic [CSBP_ADDR_W-1:0] CSBP_OFS_FLAG = 3'h4;

   // -------------------------------------------------------------------------
   // Field positions of serial_mode_reg, serial_status_reg and the flag word.
   // -------------------------------------------------------------------------
   localparam int CSBP_MODE_IFACE_EN = 7;
   localparam int CSBP_MODE_AUTO_EN = 6;
   localparam int CSBP_MODE_REPEAT = 5;
   localparam int CSBP_MODE_MASTER = 4;
   localparam int CSBP_MODE_TX_EN = 3;
   localparam int CSBP_MODE_RX_EN = 2;
   localparam int CSBP_MODE_BIT_ORDER = 1;
   localparam int CSBP_STAT_BUSY = 0;
   localparam int CSBP_STAT_BASE_CLK = 6;
   localparam int CSBP_FLAG_DONE = 0;

   // -------------------------------------------------------------------------
   // Reset values and counts.
   // -------------------------------------------------------------------------
   localparam logic [CSBP_DATA_W-1:0] CSBP_RST_BYTE = 8'h00;
   localparam logic [CSBP_DIV_W-1:0] CSBP_RST_DIV = 8'h00;
   localparam logic [2:0] CSBP_LAST_BIT = 3'h7;
   localparam logic [2:0] CSBP_FIRST_BIT = 3'h0;
   localparam logic [2:0] CSBP_BIT_STEP = 3'h1;

   // -------------------------------------------------------------------------
   // Types.
   // -------------------------------------------------------------------------
   typedef struct packed {
      logic [CSBP_ADDR_W-1:0] addr;
      logic [CSBP_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } csbp_req_s;

   typedef enum logic [1:0] {
      CSBP_IDLE = 2'b01,
      CSBP_XFER = 2'b10
   } csbp_state_e;

endpackage

// file: design/csbp_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage pin synchroniser; a change counts once stages two and three agree.
module csbp_pin_sync (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic pin_i,
   output logic level_o,
   output logic rise_o,
   output logic fall_o
);

   logic s1;
   logic s2;
   logic s3;
   logic agree;

   // -------------------------------------------------------------------------
   // Synchroniser chain; the first stage feeds only the second.
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s3 <= 1'b1;
         level_o <= 1'b1;
      end else begin
         s1 <= pin_i;
         s2 <= s1;
         s3 <= s2;
         if (agree) begin
            level_o <= s3;
         end
      end
   end

   // Edge pulses last one cycle, in the cycle before the level follows.
   assign agree = (s2 == s3);
   assign rise_o = agree & s3 & ~level_o;
   assign fall_o = agree & ~s3 & level_o;

endmodule // csbp_pin_sync
`default_nettype wire

// file: design/csbp_serial_port.sv
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
//------------------------------------------------------------------------------
// Clocked serial byte port, single-byte mode, master or slave.
//------------------------------------------------------------------------------
// Function
// - Auto bit chooses buffered, not single-byte
// - Three lines: clock, data out, data in
// - Repeat bit ignored in single-byte mode
// - Status shows only busy and base clock
// - Slave takes clock from external line
// - Shift write starts only when enabled, idle
// - Write before enable never starts transfer
// - Output on falling, capture on rising edge
// - Transmit and receive happen simultaneously
// - After eight bits stop clock, set flag
// - Shift write drives serial output low
// - Eight bits; order bit picks MSB/LSB first
// - Order reversal on bus path both ways
// - Disabled receive or transmit frees its line
// - Auto mode buffers bytes with strobe/busy (not built here; auto writes start nothing)
// - Buffer writes may be stalled by waits (not built here)
// - Disabled: output low, clock high, cleared
module csbp_serial_port
   import csbp_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire csbp_req_s bus_i,
   output logic [CSBP_DATA_W-1:0] rdata_o,
   input wire logic ser_clk_line_i,
   output logic ser_clk_line_o,
   output logic ser_clk_line_oe_o,
   output logic ser_out_line_o,
   output logic ser_out_line_oe_o,
   input wire logic ser_in_line_i,
   output logic xfer_done_irq_o,
   output logic xfer_done_flag_o
);

   // -------------------------------------------------------------------------
   // Software-visible state.
   // -------------------------------------------------------------------------
   logic [CSBP_DATA_W-1:0] serial_mode_reg;
   logic base_clock_select;
   logic [CSBP_DIV_W-1:0] clock_divisor_reg;
   logic [CSBP_DATA_W-1:0] shift_reg;
   logic xfer_done_flag;

   // -------------------------------------------------------------------------
   // Transfer engine state.
   // -------------------------------------------------------------------------
   csbp_state_e state;
   logic [2:0] bit_cnt;
   logic [CSBP_DIV_W+1:0] half_cnt;
   logic clk_level;
   logic ser_out;
   logic done_pulse;

   // Named decode and control wires.
   logic iface_enable, auto_xfer_enable, master_select, tx_enable, rx_enable, bit_order_select, xfer_busy;
   logic engine_clear, wr_mode, wr_status, wr_divisor, wr_shift, wr_flag, start_xfer;
   logic [CSBP_DATA_W-1:0] wdata_rev, shift_rev, shift_load, shift_view, next_rdata;
   logic [CSBP_DIV_W+1:0] half_period;
   logic half_tick, fall_master, rise_master, pin_clk_level, pin_clk_rise, pin_clk_fall, pin_in_level;
   logic shift_fall, shift_rise, in_bit, last_bit;

   // -------------------------------------------------------------------------
   // Pin synchronisers for the clock and data input lines.
   // -------------------------------------------------------------------------
   csbp_pin_sync u_clk_sync (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .pin_i(ser_clk_line_i),
      .level_o(pin_clk_level),
      .rise_o(pin_clk_rise),
      .fall_o(pin_clk_fall)
   );

   csbp_pin_sync u_in_sync (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .pin_i(ser_in_line_i),
      .level_o(pin_in_level),
      .rise_o(),
      .fall_o()
   );

   // -------------------------------------------------------------------------
   // Mode field decode. The repeat bit is stored but steers nothing here.
   // -------------------------------------------------------------------------
   assign iface_enable = serial_mode_reg[CSBP_MODE_IFACE_EN];
   assign auto_xfer_enable = serial_mode_reg[CSBP_MODE_AUTO_EN];
   assign master_select = serial_mode_reg[CSBP_MODE_MASTER];
   assign tx_enable = serial_mode_reg[CSBP_MODE_TX_EN];
   assign rx_enable = serial_mode_reg[CSBP_MODE_RX_EN];
   assign bit_order_select = serial_mode_reg[CSBP_MODE_BIT_ORDER];
   assign xfer_busy = (state == CSBP_XFER);

   // Clearing the enable holds the engine in reset, like a soft reset.
   assign engine_clear = reset_i | ~iface_enable;

   // Register port strobes.
   assign wr_mode = bus_i.wr & (bus_i.addr == CSBP_OFS_MODE);
   assign wr_status = bus_i.wr & (bus_i.addr == CSBP_OFS_STATUS);
   assign wr_divisor = bus_i.wr & (bus_i.addr == CSBP_OFS_DIVISOR);
   assign wr_shift = bus_i.wr & (bus_i.addr == CSBP_OFS_SHIFT);
   assign wr_flag = bus_i.wr & (bus_i.addr == CSBP_OFS_FLAG);

   // Auto mode has no byte engine in this block, so its writes start nothing.
   // A write made while disabled is dropped, so a later enable cannot start it.
   assign start_xfer = wr_shift & iface_enable & ~auto_xfer_enable & ~xfer_busy;

   // -------------------------------------------------------------------------
   // Bit-order reversal on the bus side; the shifter always moves MSB out.
   // -------------------------------------------------------------------------
   for (genvar i = 0; i < CSBP_DATA_W; i++) begin : g_rev
      assign wdata_rev[i] = bus_i.wdata[CSBP_DATA_W-1-i];
      assign shift_rev[i] = shift_reg[CSBP_DATA_W-1-i];
   end

   assign shift_load = bit_order_select ? wdata_rev : bus_i.wdata;
   assign shift_view = bit_order_select ? shift_rev : shift_reg;

   // -------------------------------------------------------------------------
   // Master clock divider: half period is (divisor + 1) base-clock steps,
   // doubled when the slower base clock is picked.
   // -------------------------------------------------------------------------
   assign half_period = ({2'b00, clock_divisor_reg} + {{(CSBP_DIV_W+1){1'b0}}, 1'b1}) << base_clock_select;
   assign half_tick = xfer_busy & master_select & (half_cnt == half_period - 1'b1);
   assign fall_master = half_tick & clk_level;
   assign rise_master = half_tick & ~clk_level;

   // Slave edges come from the synchronised line; divisor is not used then.
   assign shift_fall = master_select ? fall_master : (xfer_busy & pin_clk_fall);
   assign shift_rise = master_select ? rise_master : (xfer_busy & pin_clk_rise);
   assign in_bit = rx_enable & pin_in_level;
   assign last_bit = shift_rise & (bit_cnt == CSBP_LAST_BIT);

   // -------------------------------------------------------------------------
   // Configuration registers; only a full reset clears them.
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         serial_mode_reg <= CSBP_RST_BYTE;
         base_clock_select <= 1'b0;
         clock_divisor_reg <= CSBP_RST_DIV;
      end else begin
         if (wr_mode) begin
            serial_mode_reg <= bus_i.wdata;
         end
         if (wr_status) begin
            base_clock_select <= bus_i.wdata[CSBP_STAT_BASE_CLK];
         end
         if (wr_divisor) begin
            clock_divisor_reg <= bus_i.wdata;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Transfer state machine and bit counter.
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (engine_clear) begin
         state <= CSBP_IDLE;
         bit_cnt <= CSBP_FIRST_BIT;
      end else begin
         case (state)
            CSBP_IDLE: begin
               if (start_xfer) begin
                  state <= CSBP_XFER;
                  bit_cnt <= CSBP_FIRST_BIT;
               end
            end
            CSBP_XFER: begin
               if (last_bit) begin
                  state <= CSBP_IDLE;
               end
               if (shift_rise) begin
                  bit_cnt <= bit_cnt + CSBP_BIT_STEP;
               end
            end
            default: begin
               state <= CSBP_IDLE;
            end
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Serial clock generator; it idles high and rests high after bit eight.
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (engine_clear || start_xfer) begin
         half_cnt <= '0;
         clk_level <= 1'b1;
      end else if (half_tick) begin
         half_cnt <= '0;
         clk_level <= ~clk_level;
      end else if (xfer_busy && master_select) begin
         half_cnt <= half_cnt + 1'b1;
      end
   end

   // -------------------------------------------------------------------------
   // Shifter: present on falling, capture on the following rising edge.
   // Both directions share one shift, so send and receive run together.
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (engine_clear) begin
         shift_reg <= CSBP_RST_BYTE;
         ser_out <= 1'b0;
      end else if (start_xfer) begin
         shift_reg <= shift_load;
         ser_out <= 1'b0;
      end else begin
         if (shift_fall) begin
            ser_out <= shift_reg[CSBP_DATA_W-1];
         end
         if (shift_rise) begin
            shift_reg <= {shift_reg[CSBP_DATA_W-2:0], in_bit};
         end
      end
   end

   // -------------------------------------------------------------------------
   // Completion flag: set wins over a clear in the same cycle.
   // -------------------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         done_pulse <= 1'b0;
         xfer_done_flag <= 1'b0;
      end else begin
         done_pulse <= last_bit;
         if (last_bit) begin
            xfer_done_flag <= 1'b1;
         end else if (wr_flag && bus_i.wdata[CSBP_FLAG_DONE]) begin
            xfer_done_flag <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------------------
   // Read mux. Unused status bits and unmapped offsets read zero.
   // -------------------------------------------------------------------------
   always_comb begin
      next_rdata = CSBP_RST_BYTE;
      case (bus_i.addr)
         CSBP_OFS_MODE: next_rdata = serial_mode_reg;
         CSBP_OFS_STATUS: begin
            next_rdata[CSBP_STAT_BUSY] = xfer_busy;
            next_rdata[CSBP_STAT_BASE_CLK] = base_clock_select;
         end
         CSBP_OFS_DIVISOR: next_rdata = clock_divisor_reg;
         CSBP_OFS_SHIFT: next_rdata = shift_view;
         CSBP_OFS_FLAG: next_rdata[CSBP_FLAG_DONE] = xfer_done_flag;
         default: next_rdata = CSBP_RST_BYTE;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         rdata_o <= CSBP_RST_BYTE;
      end else if (bus_i.rd) begin
         rdata_o <= next_rdata;
      end
   end

   // -------------------------------------------------------------------------
   // Pins. Line enables free a line when its direction is off.
   // -------------------------------------------------------------------------
   assign ser_clk_line_o = clk_level;
   assign ser_clk_line_oe_o = iface_enable & master_select;
   assign ser_out_line_o = ser_out;
   assign ser_out_line_oe_o = iface_enable & tx_enable;
   assign xfer_done_irq_o = done_pulse;
   assign xfer_done_flag_o = xfer_done_flag;

   // -------------------------------------------------------------------------
   // Assertions.
   // -------------------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);

   // The launch state: busy, data line parked low, clock still resting high.
   sequence s_launch;
      xfer_busy && !ser_out_line_o && ser_clk_line_o;
   endsequence
   property p_start_busy;
      start_xfer |=> xfer_busy && (bit_cnt == CSBP_FIRST_BIT);
   endproperty
   a_start_busy: assert property (p_start_busy) else $error("Start did not raise busy.");
   property p_out_low;
      start_xfer |=> s_launch;
   endproperty
   a_out_low: assert property (p_out_low) else $error("Output not low or clock not high at start.");
   property p_no_early_write;
      (wr_shift && !iface_enable) |=> !xfer_busy;
   endproperty
   a_no_early_write: assert property (p_no_early_write) else $error("Disabled write started a transfer.");
   property p_auto_blocks;
      (wr_shift && auto_xfer_enable && !xfer_busy) |=> !xfer_busy;
   endproperty
   a_auto_blocks: assert property (p_auto_blocks) else $error("Auto mode started a byte transfer.");
   property p_disabled_pins;
      !iface_enable |=> (ser_clk_line_o && !ser_out_line_o && !xfer_busy);
   endproperty
   a_disabled_pins: assert property (p_disabled_pins) else $error("Disabled port pins wrong.");
   property p_done;
      last_bit |=> (!xfer_busy && xfer_done_flag && xfer_done_irq_o && ser_clk_line_o);
   endproperty
   a_done: assert property (p_done) else $error("Completion not signalled after bit eight.");
   property p_capture;
      shift_rise |=> shift_reg[0] == $past(in_bit);
   endproperty
   a_capture: assert property (p_capture) else $error("Input bit not captured on rising edge.");
   property p_status_read;
      (bus_i.rd && bus_i.addr == CSBP_OFS_STATUS) |=>
         (rdata_o[5:1] == 5'h00) && !rdata_o[7] && (rdata_o[CSBP_STAT_BUSY] == $past(xfer_busy));
   endproperty
   a_status_read: assert property (p_status_read) else $error("Status read shows unused bits.");
   property p_order_read;
      (bus_i.rd && bus_i.addr == CSBP_OFS_SHIFT && bit_order_select) |=> rdata_o == $past(shift_rev);
   endproperty
   a_order_read: assert property (p_order_read) else $error("Shift read not reversed.");

endmodule // csbp_serial_port
`default_nettype wire

// file: sim/csbp_peer.sv
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------------------------
// Far-side serial peripheral: shifts a byte out and one in, optionally clocking.
// -----------------------------------------------------------------------------
module csbp_peer (
   input wire logic clk_line_i,
   input wire logic data_line_i,
   input wire logic make_clk_i,
   input wire logic arm_i,
   input wire logic [7:0] tx_byte_i,
   output logic clk_o,
   output logic data_o,
   output logic [7:0] rx_byte_o
);
   logic [7:0] sh = 8'h00;
   int nb = 0;
   // The clock this model makes rests high outside frames.
   initial begin
      clk_o = 1'b1;
      data_o = 1'b0;
      rx_byte_o = 8'h00;
   end
   // Arming loads the next byte; as clock owner it then gives exactly eight pulses.
   always @(posedge arm_i) begin
      sh = tx_byte_i;
      nb = 0;
      if (make_clk_i) begin
         repeat (8) begin
            #32 clk_o = 1'b0;
            #32 clk_o = 1'b1;
         end
      end
   end
   // Our data changes on the falling edge, like the port's own.
   always @(negedge clk_line_i) begin
      data_o = sh[7];
      sh = {sh[6:0], 1'b0};
   end
   // Bits are taken on the rising edge; after the frame the line is let go and wanders.
   always @(posedge clk_line_i) begin
      rx_byte_o = {rx_byte_o[6:0], data_line_i};
      nb = nb + 1;
      if (nb == 8) begin
         #8 data_o = ~data_o;
      end
   end
endmodule // csbp_peer
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
// -----------------------------------------------------------------------------
// Self-checking bench of the serial byte port.
// -----------------------------------------------------------------------------
module tb
   import csbp_pkg::*;
;
   // Transfer table: mode, status, divisor, written byte, peer byte.
   localparam logic [7:0] T_MODE [5] = '{8'hbc, 8'h9e, 8'h98, 8'h86, 8'h8c};
   localparam logic [7:0] T_STAT [5] = '{8'h00, 8'h40, 8'h00, 8'h00, 8'h40};
   localparam logic [7:0] T_DIV [5] = '{8'h07, 8'h02, 8'h04, 8'h00, 8'h00};
   localparam logic [7:0] T_TX [5] = '{8'hc1, 8'h1d, 8'h6e, 8'h55, 8'h93};
   localparam logic [7:0] T_PEER [5] = '{8'h3a, 8'hb4, 8'hff, 8'h2c, 8'h47};
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   csbp_req_s bus = '0;
   logic [7:0] rdata, peer_rx, irq_n = 8'h00;
   logic [7:0] peer_tx = 8'h00;
   logic sck_o, sck_oe, so, so_oe, irq, flag, peer_clk, peer_dat;
   logic arm = 1'b0, mk = 1'b0, prev_sck = 1'b1, ord;
   logic [7:0] m;
   logic [2:0] k;
   int error_cnt = 0, n_compared = 0, cyc = 0, last_fall = 0, gap = 0;
   // A released clock line follows the peer's clock; a released data line shows the inverse of the port's output value.
   wire sck_w = sck_oe ? sck_o : peer_clk;
   wire so_w = so_oe ? so : ~so;
   csbp_serial_port i_dut (
      .clk_sys_i(clk_sys), .reset_i(reset), .bus_i(bus), .rdata_o(rdata),
      .ser_clk_line_i(sck_w), .ser_clk_line_o(sck_o), .ser_clk_line_oe_o(sck_oe),
      .ser_out_line_o(so), .ser_out_line_oe_o(so_oe), .ser_in_line_i(peer_dat),
      .xfer_done_irq_o(irq), .xfer_done_flag_o(flag));
   csbp_peer i_peer (
      .clk_line_i(sck_w), .data_line_i(so_w), .make_clk_i(mk), .arm_i(arm),
      .tx_byte_i(peer_tx), .clk_o(peer_clk), .data_o(peer_dat), .rx_byte_o(peer_rx));
   // System clock of 4 ns.
   initial forever #2 clk_sys = ~clk_sys;
   // Counts interrupt pulses and measures the spacing of serial clock falls.
   always @(posedge clk_sys) begin
      cyc = cyc + 1;
      if (irq === 1'b1) irq_n = irq_n + 8'h01;
      if (prev_sck === 1'b1 && sck_o === 1'b0) begin
         gap = cyc - last_fall;
         last_fall = cyc;
      end
      prev_sck = sck_o;
   end
   function automatic logic [7:0] rev(input logic [7:0] v);
      for (int i = 0; i < 8; i++) rev[i] = v[7-i];
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys) bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_sys) bus <= '0;
   endtask
   // Read data appear in the cycle after the strobe and hold until the next read; they are taken there.
   task automatic rd(input logic [2:0] a);
      @(posedge clk_sys) bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk_sys) bus <= '0;
      #1;
   endtask
   task automatic rc(input logic [2:0] a, input logic [7:0] exp);
      rd(a);
      chk(rdata, exp);
   endtask
   task automatic wait_idle;
      int i;
      for (i = 0; i < 400; i++) begin
         rd(CSBP_OFS_STATUS);
         if (rdata[0] === 1'b0) break;
      end
      if (i == 400) begin
         error_cnt++;
         $display("[ERR] %0t: transfer never ended", $time);
         summarize();
      end
   endtask
   task automatic summarize;
      $display("mismatches %0d, comparisons %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // Main sequence.
   initial begin
      repeat (12) @(posedge clk_sys);
      reset <= 1'b0;
      for (k = 3'h0; k < 3'h6; k++) rc(k, 8'h00);
      chk({5'h00, sck_o, so, sck_oe | so_oe}, 8'h04);
      wr(CSBP_OFS_SHIFT, 8'h5a);
      wr(CSBP_OFS_MODE, 8'h90);
      rc(CSBP_OFS_STATUS, 8'h00);
      wr(CSBP_OFS_MODE, 8'hd0);
      wr(CSBP_OFS_SHIFT, 8'h5a);
      rc(CSBP_OFS_STATUS, 8'h00);
      // Each table row: configure in order, start, refuse a second start, then check the port end, and the peer end when transmit is on.
      for (k = 3'h0; k < 3'h5; k++) begin
         m = T_MODE[k];
         ord = m[1];
         wr(CSBP_OFS_STATUS, T_STAT[k]);
         wr(CSBP_OFS_DIVISOR, T_DIV[k]);
         wr(CSBP_OFS_MODE, m);
         peer_tx <= T_PEER[k];
         mk <= ~m[4];
         arm <= m[4];
         wr(CSBP_OFS_SHIFT, T_TX[k]);
         #1 chk({7'h00, so}, 8'h00);
         chk({6'h00, sck_oe, so_oe}, {6'h00, m[4], m[3]});
         rc(CSBP_OFS_STATUS, T_STAT[k] | 8'h01);
         wr(CSBP_OFS_SHIFT, 8'h00);
         arm <= 1'b1;
         wait_idle();
         arm <= 1'b0;
         if (m[4]) chk(gap[7:0], (T_DIV[k] + 8'h01) << (1 + T_STAT[k][6]));
         rc(CSBP_OFS_STATUS, T_STAT[k]);
         chk({7'h00, flag}, 8'h01);
         chk(irq_n, {5'h00, k} + 8'h01);
         rc(CSBP_OFS_SHIFT, m[2] ? (ord ? rev(T_PEER[k]) : T_PEER[k]) : 8'h00);
         if (m[3]) chk(peer_rx, ord ? rev(T_TX[k]) : T_TX[k]);
         wr(CSBP_OFS_FLAG, 8'h01);
         rc(CSBP_OFS_FLAG, 8'h00);
         rc(CSBP_OFS_MODE, m);
      end
      // Dropping the enable in mid-transfer must park the lines and clear the engine.
      wr(CSBP_OFS_DIVISOR, 8'h07);
      wr(CSBP_OFS_STATUS, 8'h00);
      wr(CSBP_OFS_MODE, 8'hbc);
      wr(CSBP_OFS_SHIFT, 8'hf0);
      repeat (20) @(posedge clk_sys);
      wr(CSBP_OFS_MODE, 8'h3c);
      @(posedge clk_sys) #1 chk({5'h00, sck_o, so, sck_oe | so_oe}, 8'h04);
      rc(CSBP_OFS_STATUS, 8'h00);
      repeat (300) @(posedge clk_sys);
      chk(irq_n, 8'h05);
      summarize();
   end
endmodule // tb
`default_nettype wire
